// ===== src/bpwc_defines.svh
`ifndef BPWC_DEFINES_SVH
`define BPWC_DEFINES_SVH
// ==========================================================
// register offsets inside one counter window
`define BPWC_CTRL 6'h00
`define BPWC_CMD 6'h04
`define BPWC_LOAD 6'h08
`define BPWC_BUFLEN 6'h0C
`define BPWC_COUNT 6'h10
`define BPWC_STATUS 6'h14
`define BPWC_POINTS 6'h18
`define BPWC_DATA 6'h1C
// address bit choosing counter zero or counter one
`define BPWC_CH_BIT 6
// ==========================================================
// control word fields
`define BPWC_F_MODE 2:0
`define BPWC_F_EDGE 3
`define BPWC_F_GLVL 4
`define BPWC_F_TB 6:5
`define BPWC_F_SRC 11:8
`define BPWC_F_GATE 15:12
// command bits
`define BPWC_C_ARM 0
`define BPWC_C_DISARM 1
// status bits
`define BPWC_S_ARMED 0
`define BPWC_S_TC 1
`define BPWC_S_DONE 2
`define BPWC_S_OUT 3
`define BPWC_S_CMPL 4
// ==========================================================
// reset values
`define BPWC_GATE0_RST 4'h9
`define BPWC_GATE1_RST 4'h4
`define BPWC_LOAD_RST 24'h000001
`define BPWC_BUFLEN_RST 8'h10
// ==========================================================
// timing
`define BPWC_CNT_W 24
`define BPWC_CLK_HZ 40000000
`define BPWC_FAST_HZ 20000000
`define BPWC_SLOW_HZ 100000
`define BPWC_FAST_HALF (`BPWC_CLK_HZ / (2 * `BPWC_FAST_HZ))
`define BPWC_SLOW_HALF (`BPWC_CLK_HZ / (2 * `BPWC_SLOW_HZ))
`endif

// ===== src/bpwc_pkg.sv
package bpwc_pkg;
    // ======================================================
    // counter applications
    typedef enum logic [2:0] {
        BPWC_M_BUF_WIDTH = 3'h0,
        BPWC_M_ONE_WIDTH = 3'h1,
        BPWC_M_TRAIN = 3'h2,
        BPWC_M_TRIG = 3'h3,
        BPWC_M_RETRIG = 3'h4
    } bpwc_mode_t;
    // timebase choices
    typedef enum logic [1:0] {
        BPWC_TB_FAST = 2'h0,
        BPWC_TB_SLOW = 2'h1,
        BPWC_TB_PIN = 2'h2,
        BPWC_TB_PARTNER = 2'h3
    } bpwc_tb_t;
    // counter arm state, one-hot
    typedef enum logic [1:0] {
        BPWC_IDLE = 2'h1,
        BPWC_ARMED = 2'h2
    } bpwc_state_t;
endpackage

// ===== src/bpwc_store.sv
`timescale 1ns/100ps
// ==========================================================
// sample store: fills once after arming, drained by reads
module bpwc_store #(
    parameter int W = 24,
    parameter int DEPTH = 16,
    parameter int PW = $clog2(DEPTH) + 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // fill side
    input wire logic clr,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    // drain side
    input wire logic rd_en,
    output logic [W-1:0] rd_data,
    output logic [PW-1:0] filled,
    output logic [PW-1:0] avail
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [PW-1:0] FULL = PW'(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_reg;
    logic [PW-1:0] rd_reg;
    wire do_wr = wr_en & (wr_reg != FULL);
    wire do_rd = rd_en & (avail != '0);

    assign filled = wr_reg;
    assign avail = wr_reg - rd_reg;
    assign rd_data = mem[rd_reg[AW-1:0]];

    // pointers never wrap: the store is refilled only after a new arm
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (clr) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + PW'(do_wr);
            rd_reg <= rd_reg + PW'(do_rd);
        end
    end

    // storage itself needs no reset
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_reg[AW-1:0]] <= wr_data;
        end
    end
endmodule

// ===== src/bpwc_top.sv
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "bpwc_defines.svh"
module bpwc_top #(
    parameter int NPIN = 10,
    parameter int DEPTH = 16,
    parameter int CW = `BPWC_CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // programmable function input pins
    input wire logic [NPIN-1:0] programmable_function_input,
    // counter outputs
    output logic [1:0] ctr_out
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam logic [7:0] FAST_HALF = 8'(`BPWC_FAST_HALF);
    localparam logic [7:0] SLOW_HALF = 8'(`BPWC_SLOW_HALF);
    localparam logic [8:0] DEPTH9 = 9'(DEPTH);

    // ======================================================
    // pin synchronisers
    logic [NPIN-1:0] fin_s1_reg;
    logic [NPIN-1:0] fin_s2_reg;
    wire [15:0] fin_ext = 16'(fin_s2_reg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fin_s1_reg <= '0;
            fin_s2_reg <= '0;
        end else begin
            fin_s1_reg <= programmable_function_input;
            fin_s2_reg <= fin_s1_reg;
        end
    end

    // ======================================================
    // internal timebases, square waves derived from clk
    logic [7:0] fast_div_reg;
    logic [7:0] slow_div_reg;
    logic fast_lvl_reg;
    logic slow_lvl_reg;
    wire fast_wrap = fast_div_reg == FAST_HALF - 8'h01;
    wire slow_wrap = slow_div_reg == SLOW_HALF - 8'h01;

    // fast level toggles every cycle: a rising edge every 50 ns
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fast_div_reg <= 8'h00;
            slow_div_reg <= 8'h00;
            fast_lvl_reg <= 1'b0;
            slow_lvl_reg <= 1'b0;
        end else begin
            fast_div_reg <= fast_wrap ? 8'h00 : fast_div_reg + 8'h01;
            fast_lvl_reg <= fast_lvl_reg ^ fast_wrap;
            slow_div_reg <= slow_wrap ? 8'h00 : slow_div_reg + 8'h01;
            slow_lvl_reg <= slow_lvl_reg ^ slow_wrap;
        end
    end

    // ======================================================
    // bus slave: one wait cycle, then the request is accepted
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] ch_rd [2];
    wire req = avs_read | avs_write;
    wire acc = req & ack_reg;
    wire bus_ch = avs_address[`BPWC_CH_BIT];
    wire [5:0] off = avs_address[5:0];
    wire hi_addr = avs_address[7];
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] rd_mux = hi_addr ? 32'h0000_0000 : ch_rd[bus_ch];

    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata = rdata_reg;

    // read data is captured in the wait cycle, before any pop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (avs_read & ~ack_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // ======================================================
    // counter state, one slot per counter
    logic [31:0] ctrl_reg [2];
    logic [CW-1:0] load_reg [2];
    logic [7:0] buflen_reg [2];
    logic [CW-1:0] cnt_reg [2];
    bpwc_pkg::bpwc_state_t st_reg [2];
    logic [1:0] tc_reg;
    logic [1:0] done_reg;
    logic [1:0] out_reg;
    logic [1:0] cmpl_reg;
    logic [1:0] first_reg;
    logic [1:0] gprev_reg;
    logic [1:0] tprev_reg;
    logic [1:0] tc_evt_reg;

    assign ctr_out = out_reg;

    genvar g;
    for (g = 0; g < 2; g++) begin : gen_ctr
        localparam logic [3:0] GATE_RST =
            (g == 0) ? `BPWC_GATE0_RST : `BPWC_GATE1_RST;
        localparam logic [31:0] CTRL_RST =
            {16'h0000, GATE_RST, 12'h000};
        wire [31:0] cfg = ctrl_reg[g];
        wire [CW-1:0] cnt = cnt_reg[g];
        wire bpwc_pkg::bpwc_mode_t mode =
            bpwc_pkg::bpwc_mode_t'(cfg[`BPWC_F_MODE]);
        wire bpwc_pkg::bpwc_tb_t tbs =
            bpwc_pkg::bpwc_tb_t'(cfg[`BPWC_F_TB]);
        wire m_buf = mode == bpwc_pkg::BPWC_M_BUF_WIDTH;
        wire m_one = mode == bpwc_pkg::BPWC_M_ONE_WIDTH;
        wire m_train = mode == bpwc_pkg::BPWC_M_TRAIN;
        wire m_retrig = mode == bpwc_pkg::BPWC_M_RETRIG;
        wire m_pulse = m_retrig | (mode == bpwc_pkg::BPWC_M_TRIG);
        wire armed = st_reg[g] == bpwc_pkg::BPWC_ARMED;

        // timebase selection and edge choice
        wire tb_pin = fin_ext[cfg[`BPWC_F_SRC]];
        wire tb_lvl = (tbs == bpwc_pkg::BPWC_TB_FAST) ? fast_lvl_reg :
                      (tbs == bpwc_pkg::BPWC_TB_SLOW) ? slow_lvl_reg :
                      (tbs == bpwc_pkg::BPWC_TB_PIN) ? tb_pin :
                      tc_evt_reg[1-g];
        wire tick = cfg[`BPWC_F_EDGE] ? (tprev_reg[g] & ~tb_lvl) :
                    (~tprev_reg[g] & tb_lvl);

        // gate polarity folded in, so the rest sees active pulses
        wire g_act = fin_ext[cfg[`BPWC_F_GATE]] ^ cfg[`BPWC_F_GLVL];
        wire g_rise = g_act & ~gprev_reg[g];
        wire g_fall = ~g_act & gprev_reg[g];

        // register decode for this counter
        wire sel = acc & ~hi_addr & (bus_ch == 1'(g));
        wire wr = sel & avs_write;
        wire wcmd = wr & (off == `BPWC_CMD) & avs_byteenable[0];
        wire do_arm = wcmd & avs_writedata[`BPWC_C_ARM];
        wire do_dis = wcmd & avs_writedata[`BPWC_C_DISARM];
        wire st_rd = sel & avs_read & (off == `BPWC_STATUS);
        wire pop = sel & avs_read & (off == `BPWC_DATA);
        wire [31:0] wmerge = (avs_writedata & be_mask);

        // counting and measurement events
        wire hit = tick & (cnt == load_reg[g]);
        wire fire = armed & m_pulse & g_rise & (m_retrig | ~out_reg[g]);
        wire end_p = armed & m_pulse & out_reg[g] & hit & ~fire;
        wire tc_hit = armed & m_train & hit;
        wire run = m_buf ? (first_reg[g] | g_act) :
                   m_one ? g_act :
                   m_train ? 1'b1 : out_reg[g];
        wire inc = armed & tick & run;
        wire ovf = inc & (&cnt);
        wire meas_end = armed & (m_buf | m_one) & g_fall;
        wire push = meas_end & m_buf;
        wire [PW-1:0] filled;
        wire [PW-1:0] avail;
        wire [CW-1:0] sdata;
        wire [8:0] fill9 = 9'(filled) + 9'h001;
        wire buf_last = push & ((fill9 >= 9'(buflen_reg[g])) |
                        (fill9 >= DEPTH9));
        wire stop = buf_last | (meas_end & m_one) |
                    (end_p & ~m_retrig);
        wire restart = push | fire | tc_hit | end_p;

        // next values
        wire [CW-1:0] cnt_next = do_arm ? '0 : restart ? '0 :
                                 inc ? cnt + 1'b1 : cnt;
        // arm state: disarm beats arm, arm beats a stop in the same cycle
        bpwc_pkg::bpwc_state_t st_next;
        always_comb begin
            st_next = st_reg[g];
            case (st_reg[g])
                bpwc_pkg::BPWC_IDLE: begin
                    if (do_arm & ~do_dis) begin
                        st_next = bpwc_pkg::BPWC_ARMED;
                    end
                end
                bpwc_pkg::BPWC_ARMED: begin
                    if (do_dis | (stop & ~do_arm)) begin
                        st_next = bpwc_pkg::BPWC_IDLE;
                    end
                end
                default: begin
                    st_next = bpwc_pkg::BPWC_IDLE;
                end
            endcase
        end
        wire first_next = do_arm | (first_reg[g] & ~meas_end);
        wire tc_next = ~do_arm & (ovf | tc_hit | tc_reg[g]);
        // a pulse end in the clearing read cycle stays reported
        wire done_next = end_p | (done_reg[g] & ~st_rd & ~do_arm);
        wire out_next = do_arm ? 1'b0 : tc_hit ? ~out_reg[g] :
                        fire ? 1'b1 : end_p ? 1'b0 : out_reg[g];
        wire cmpl_next = ~do_arm &
                         ((meas_end & m_one) | cmpl_reg[g]);
        wire [31:0] ctrl_next = (wr & (off == `BPWC_CTRL)) ?
                                ((cfg & ~be_mask) | wmerge) : cfg;
        wire [31:0] load_w = (32'(load_reg[g]) & ~be_mask) | wmerge;
        wire [31:0] blen_w = (32'(buflen_reg[g]) & ~be_mask) | wmerge;

        // status word for software
        logic [31:0] stat;
        always_comb begin
            stat = 32'h0000_0000;
            stat[`BPWC_S_ARMED] = armed;
            stat[`BPWC_S_TC] = tc_reg[g];
            stat[`BPWC_S_DONE] = done_reg[g];
            stat[`BPWC_S_OUT] = out_reg[g];
            stat[`BPWC_S_CMPL] = cmpl_reg[g];
        end

        // read selection, unmapped offsets read as zero
        assign ch_rd[g] =
            (off == `BPWC_CTRL) ? cfg :
            (off == `BPWC_LOAD) ? 32'(load_reg[g]) :
            (off == `BPWC_BUFLEN) ? 32'(buflen_reg[g]) :
            (off == `BPWC_COUNT) ? 32'(cnt) :
            (off == `BPWC_STATUS) ? stat :
            (off == `BPWC_POINTS) ? 32'(avail) :
            (off == `BPWC_DATA) ? 32'(sdata) : 32'h0000_0000;

        // software-written configuration
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ctrl_reg[g] <= CTRL_RST;
                load_reg[g] <= `BPWC_LOAD_RST;
                buflen_reg[g] <= `BPWC_BUFLEN_RST;
            end else begin
                ctrl_reg[g] <= ctrl_next;
                if (wr & (off == `BPWC_LOAD)) begin
                    load_reg[g] <= load_w[CW-1:0];
                end
                if (wr & (off == `BPWC_BUFLEN)) begin
                    buflen_reg[g] <= blen_w[7:0];
                end
            end
        end

        // counter core state
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                cnt_reg[g] <= '0;
                st_reg[g] <= bpwc_pkg::BPWC_IDLE;
                tc_reg[g] <= 1'b0;
                done_reg[g] <= 1'b0;
                out_reg[g] <= 1'b0;
                cmpl_reg[g] <= 1'b0;
                first_reg[g] <= 1'b0;
                gprev_reg[g] <= 1'b0;
                tprev_reg[g] <= 1'b0;
                tc_evt_reg[g] <= 1'b0;
            end else begin
                cnt_reg[g] <= cnt_next;
                st_reg[g] <= st_next;
                tc_reg[g] <= tc_next;
                done_reg[g] <= done_next;
                out_reg[g] <= out_next;
                cmpl_reg[g] <= cmpl_next;
                first_reg[g] <= first_next;
                gprev_reg[g] <= g_act;
                tprev_reg[g] <= tb_lvl;
                tc_evt_reg[g] <= tc_hit;
            end
        end

        // buffer of measured widths; software drains it after disarm
        bpwc_store #(
            .W(CW),
            .DEPTH(DEPTH),
            .PW(PW)
        ) u_store (
            .clk(clk),
            .arst_n(arst_n),
            .clr(do_arm),
            .wr_en(push),
            .wr_data(cnt),
            .rd_en(pop),
            .rd_data(sdata),
            .filled(filled),
            .avail(avail)
        );
    end
endmodule

// ===== tb/bpwc_monitor.sv
`timescale 1ns/100ps
// ==========================================================
// bus and status checks seen from the top ports
module bpwc_monitor #(
    parameter int NPIN = 10,
    parameter int DEPTH = 16,
    parameter int CW = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins and counter outputs
    input wire logic [NPIN-1:0] programmable_function_input,
    input wire logic [1:0] ctr_out
);
    // a mapped read is taken where waitrequest is low
    wire rd_take = avs_read && !avs_waitrequest && !avs_address[7];
    wire req = avs_read || avs_write;
    wire [5:0] off = avs_address[5:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    one_wait_a: assert property (
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    first_wait_a: assert property (
        req && !$past(req) |-> avs_waitrequest)
        else $error("new request not held for one wait cycle");
    idle_free_a: assert property (
        !req |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    hole_zero_a: assert property (
        avs_read && !avs_waitrequest && avs_address[7]
        |-> avs_readdata == 32'h0)
        else $error("unmapped read returned data");
    data_hold_a: assert property (
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved outside a read");
    count_width_a: assert property (
        rd_take && off == 6'h10 |-> (avs_readdata >> CW) == 32'h0)
        else $error("count wider than the counter");
    status_bits_a: assert property (
        rd_take && off == 6'h14 |-> avs_readdata[31:5] == 27'h0)
        else $error("status reserved bits set");
    points_max_a: assert property (
        rd_take && off == 6'h18 |-> avs_readdata <= DEPTH)
        else $error("point count beyond store depth");
    out_reset_a: assert property (
        $rose(arst_n) |-> ctr_out == 2'h0)
        else $error("counter output not low after reset");
endmodule

// ===== tb/bpwc_pin_src.sv
`timescale 1ns/100ps
// ==========================================================
// far side: gate pulses and an external timebase on the pins
module bpwc_pin_src (
    // clock
    input wire logic clk,
    // function input pins
    output logic [9:0] pins
);
    logic ext_run;
    logic [1:0] div;
    // pins start low, so default gates idle inactive
    initial begin
        pins = 10'h000;
        ext_run = 1'h0;
        div = 2'h0;
    end
    // free running timebase on pin 2, eight clocks a period
    always @(posedge clk) begin
        if (ext_run) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                pins[2] <= ~pins[2];
            end
        end
    end
    // one pin level change, just after a clock edge
    task automatic drive(input int pin, input logic lvl);
        @(posedge clk);
        pins[pin] <= lvl;
    endtask
    // pulse then equal gap; widths stay far above a tick
    task automatic pulse(input int pin, input int width,
            input logic low);
        drive(pin, ~low);
        repeat (width - 1) @(posedge clk);
        drive(pin, low);
        repeat (width) @(posedge clk);
    endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
// ==========================================================
// register-level bench for the two pulse width counters
module tb;
    localparam logic WR = 1'h1;
    localparam logic RD = 1'h0;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [9:0] pins;
    logic [1:0] ctr_out;
    logic [31:0] v;
    logic [7:0] rst_a [8] = '{8'h00, 8'h40, 8'h08, 8'h0C, 8'h14,
        8'h18, 8'h80, 8'h20};
    logic [31:0] rst_v [8] = '{32'h9000, 32'h4000, 32'h1, 32'h10,
        32'h0, 32'h0, 32'h0, 32'h0};
    int failures = 0;
    int tests_run = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    bpwc_top #(.NPIN(10), .DEPTH(16), .CW(24)) dut (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .programmable_function_input(pins), .ctr_out(ctr_out));
    bpwc_pin_src src (.clk(clk), .pins(pins));
    // ======================================================
    // verdict and comparison
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // tick counts carry one tick of phase uncertainty
    task automatic near(input string name, input int e);
        check(name, {31'h0, v >= e - 1 && v <= e + 1}, 32'h1);
    endtask
    // one bus access held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 40);
        v = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
        if (n >= 40) begin
            failures++;
            report_and_stop();
        end
    endtask
    // poll status until the counter disarms, bounded
    task automatic wait_idle(input logic [7:0] a);
        int n;
        n = 0;
        do begin
            bus(RD, a, 32'h0);
            n++;
        end while (v[0] !== 1'h0 && n < 100);
        check("armed low", {31'h0, v[0]}, 32'h0);
        // a counter that never disarms ends the run here
        if (v[0] !== 1'h0) begin
            report_and_stop();
        end
    endtask
    // arm for two points, send two pulses, drain the store
    task automatic run_buf(input logic [7:0] b, input int pin,
            input int width, input logic low, input int e);
        bus(WR, b | 8'h0C, 32'h2);
        bus(WR, b | 8'h04, 32'h1);
        bus(RD, b | 8'h14, 32'h0);
        check("armed", {31'h0, v[0]}, 32'h1);
        repeat (2) src.pulse(pin, width, low);
        wait_idle(b | 8'h14);
        bus(RD, b | 8'h18, 32'h0);
        check("points", v, 32'h2);
        bus(RD, b | 8'h1C, 32'h0);
        bus(RD, b | 8'h1C, 32'h0);
        near("width", e);
        bus(RD, b | 8'h18, 32'h0);
        check("drained", v, 32'h0);
        $display("test ended: buffered run, width %0d", width);
    endtask
    // ======================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        bus(WR, 8'h80, 32'hFFFF);
        for (int i = 0; i < 8; i++) begin
            bus(RD, rst_a[i], 32'h0);
            check("reset value", v, rst_v[i]);
        end
        $display("test ended: reset values");
        run_buf(8'h00, 9, 200, 1'h0, 100);
        // counter one: slow timebase, low pulses on pin 4
        bus(WR, 8'h40, 32'h4030);
        src.drive(4, 1'h1);
        repeat (6) @(posedge clk);
        run_buf(8'h40, 4, 2000, 1'h1, 5);
        src.drive(4, 1'h0);
        // pin timebase on falling edges
        src.ext_run <= 1'h1;
        bus(WR, 8'h00, 32'h9248);
        run_buf(8'h00, 9, 160, 1'h0, 20);
        src.ext_run <= 1'h0;
        // counter one makes a train, one tick every ten clocks
        bus(WR, 8'h40, 32'h4002);
        bus(WR, 8'h48, 32'h4);
        bus(WR, 8'h44, 32'h1);
        bus(WR, 8'h00, 32'h9060);
        run_buf(8'h00, 9, 400, 1'h0, 40);
        bus(RD, 8'h54, 32'h0);
        check("train tc", {31'h0, v[1]}, 32'h1);
        bus(WR, 8'h44, 32'h2);
        // single triggered pulse, four ticks long
        bus(WR, 8'h40, 32'h4003);
        bus(WR, 8'h48, 32'h3);
        bus(WR, 8'h44, 32'h1);
        src.drive(4, 1'h1);
        repeat (8) @(posedge clk);
        check("out high", {31'h0, ctr_out[1]}, 32'h1);
        repeat (40) @(posedge clk);
        src.drive(4, 1'h0);
        bus(RD, 8'h54, 32'h0);
        check("trig status", v & 32'h0D, 32'h04);
        bus(RD, 8'h54, 32'h0);
        check("done once", v & 32'h04, 32'h0);
        $display("test ended: triggered pulse");
        // retriggerable pulse stays armed, done per pulse
        bus(WR, 8'h40, 32'h4004);
        bus(WR, 8'h44, 32'h1);
        for (int i = 0; i < 2; i++) begin
            src.pulse(4, 40, 1'h0);
            bus(RD, 8'h54, 32'h0);
            check("retrig", v & 32'h05, 32'h05);
        end
        bus(WR, 8'h44, 32'h2);
        $display("test ended: retriggerable pulse");
        // single width measurement
        bus(WR, 8'h00, 32'h9001);
        bus(WR, 8'h04, 32'h1);
        bus(RD, 8'h14, 32'h0);
        check("not complete", v & 32'h10, 32'h0);
        src.pulse(9, 120, 1'h0);
        bus(RD, 8'h14, 32'h0);
        check("complete", v & 32'h11, 32'h10);
        bus(RD, 8'h10, 32'h0);
        near("single width", 60);
        $display("test ended: single width");
        report_and_stop();
    end
endmodule
// checker on the top ports
bind bpwc_top bpwc_monitor #(.NPIN(NPIN), .DEPTH(DEPTH), .CW(CW)) mon (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .programmable_function_input(programmable_function_input),
    .ctr_out(ctr_out));
